//--- hdl/fpma_pkg.sv
`default_nettype none
package fpma_pkg;

  // special function register select codes
  localparam logic [1:0] REG_CONTROL = 2'h0;
  localparam logic [1:0] REG_UNLOCK  = 2'h1;
  localparam logic [1:0] REG_LATCH   = 2'h2;

  // control register field positions
  localparam int unsigned BIT_MEM_SEL  = 7;
  localparam int unsigned BIT_CFG_SEL  = 6;
  localparam int unsigned BIT_ERASE    = 4;
  localparam int unsigned BIT_ABORT    = 3;
  localparam int unsigned BIT_PROG_EN  = 2;
  localparam int unsigned BIT_START    = 1;
  localparam int unsigned BIT_RD_START = 0;

  // reset values of the control fields, the table latch and the holding bytes
  localparam logic CTL_RST_MEM_SEL = 1'b0;
  localparam logic CTL_RST_CFG_SEL = 1'b0;
  localparam logic CTL_RST_ERASE   = 1'b0;
  localparam logic CTL_RST_ABORT   = 1'b0;
  localparam logic CTL_RST_PROG_EN = 1'b0;
  localparam logic CTL_RST_START   = 1'b0;
  localparam logic CTL_RST_RD      = 1'b0;
  localparam logic [7:0] LATCH_RST = 8'h00;
  localparam logic [7:0] HOLD_RST  = 8'hff;

  // unlock sequence bytes
  localparam logic [7:0] UNLOCK_KEY1 = 8'h55;
  localparam logic [7:0] UNLOCK_KEY2 = 8'haa;

  // geometry
  localparam int unsigned PTR_W       = 22;
  localparam int unsigned WRITE_BYTES = 8;
  localparam int unsigned ERASE_BYTES = 64;
  localparam int unsigned WRITE_LSB   = 3;
  localparam int unsigned ERASE_LSB   = 6;

  // executed in place of an invalid instruction word
  localparam logic [15:0] NOP_WORD = 16'h0000;

  // target codes
  localparam logic [1:0] TGT_EEPROM = 2'h0;
  localparam logic [1:0] TGT_FLASH  = 2'h1;
  localparam logic [1:0] TGT_CONFIG = 2'h2;

  // self-timed cycle length
  localparam int unsigned CLK_FREQ_MHZ = 40;
  localparam int unsigned PROG_TIME_US = 2000;
  localparam int unsigned PROG_CYCLES  = PROG_TIME_US * CLK_FREQ_MHZ;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_ARMED = 3'b010,
    ST_KEYED = 3'b100
  } fpma_unlock_t;

endpackage
`default_nettype wire

//--- hdl/fpma_prog_timer.sv
`timescale 1ns/1ps
`default_nettype none
module fpma_prog_timer #(
  parameter int unsigned CYCLES = fpma_pkg::PROG_CYCLES
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic start,
  input  wire logic abort,
  output logic      busy,
  output logic      done
);

  localparam int unsigned CW = $clog2(CYCLES + 1);

  generate
    if (CYCLES < 2) begin : g_bad_cycles
      $error("programming timer needs at least two cycles");
    end
  endgenerate

  logic [CW-1:0] cnt_ff;
  logic [CW-1:0] nxt_cnt;
  logic          busy_ff;
  logic          nxt_busy;
  logic          done_ff;
  logic          nxt_done;

  always_comb begin
    nxt_cnt  = cnt_ff;
    nxt_busy = busy_ff;
    nxt_done = 1'b0;
    if (abort) begin
      nxt_busy = 1'b0;
      nxt_cnt  = '0;
    end else if (start && !busy_ff) begin
      nxt_busy = 1'b1;
      nxt_cnt  = CW'(CYCLES - 1);
    end else if (busy_ff) begin
      if (cnt_ff == '0) begin
        nxt_busy = 1'b0;
        nxt_done = 1'b1;
      end else begin
        nxt_cnt = cnt_ff - CW'(1);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_ff  <= '0;
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
    end else begin
      cnt_ff  <= nxt_cnt;
      busy_ff <= nxt_busy;
      done_ff <= nxt_done;
    end
  end

  assign busy = busy_ff;
  assign done = done_ff;

endmodule // fpma_prog_timer
`default_nettype wire

//--- hdl/fpma_top.sv
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - byte reads, 8-byte writes, 64-byte row erases
// - stall fetch and memory during write/erase
// - internal timer ends every write or erase
// - invalid instruction word executes as no-op
// - bytes move only through 8-bit table latch
// - table store fills holding register, not array
// - table operations address any single byte
// - unlock register has no storage, reads zero
// - memory select picks flash or EEPROM
// - config select overrides memory select
// - erase bit erases row, cleared on completion
// - program enable gates writes, clear at power-up
// - abort flag set at start, cleared at end
// - abort keeps memory and config select bits
// - start bit set-only, hardware clears it
// - completion flag set, software clears it
// - read bit one-cycle, set-only, refused on selects
// - control bit 5 reads as zero
// - table latch is an 8-bit register
// - erase row from pointer bits 21 to 6
// - holding byte from bits 2:0, block 21:3
module fpma_top #(
  parameter int unsigned PROG_CYCLES = fpma_pkg::PROG_CYCLES,
  parameter int unsigned PTR_W       = fpma_pkg::PTR_W,
  parameter int unsigned HOLD_BYTES  = fpma_pkg::WRITE_BYTES
) (
  input  wire logic                  REF_CLK,
  input  wire logic                  RST,
  input  wire logic                  WARM_RST,
  input  wire logic                  SFR_WR,
  input  wire logic                  SFR_RD,
  input  wire logic [1:0]            SFR_SEL,
  input  wire logic [7:0]            SFR_WDATA,
  output logic      [7:0]            SFR_RDATA,
  input  wire logic                  TBL_FETCH,
  input  wire logic                  TBL_STORE,
  input  wire logic [PTR_W-1:0]      TBL_PTR,
  output logic      [PTR_W-2:0]      MEM_RADDR,
  input  wire logic [15:0]           MEM_RDATA,
  input  wire logic [15:0]           FETCH_WORD,
  input  wire logic                  FETCH_INVALID,
  output logic      [15:0]           EXEC_WORD,
  output logic                       FETCH_HOLD,
  output logic                       ARR_WRITE,
  output logic                       ARR_ERASE,
  output logic      [1:0]            ARR_TARGET,
  output logic      [PTR_W-1:0]      ARR_ADDR,
  output logic      [8*HOLD_BYTES-1:0] ARR_WDATA,
  output logic                       EE_READ,
  input  wire logic                  NVM_DONE_CLR,
  output logic                       NVM_DONE_FLAG
);

  localparam int unsigned HSEL_W = $clog2(HOLD_BYTES);

  generate
    if (HOLD_BYTES != fpma_pkg::WRITE_BYTES ||
        PTR_W <= fpma_pkg::ERASE_LSB) begin : g_bad_geom
      $error("holding block must be 8 bytes and pointer wider than 6");
    end
  endgenerate

  logic                     mem_sel_ff, nxt_mem_sel;
  logic                     cfg_sel_ff, nxt_cfg_sel;
  logic                     erase_ff, nxt_erase;
  logic                     abort_ff, nxt_abort;
  logic                     prog_en_ff, nxt_prog_en;
  logic                     start_ff, nxt_start;
  logic                     rd_ff, nxt_rd;
  logic [7:0]               latch_ff, nxt_latch;
  logic [7:0]               rdata_ff, nxt_rdata;
  logic [7:0]               hold_ff [HOLD_BYTES];
  logic [7:0]               nxt_hold [HOLD_BYTES];
  logic [PTR_W-1:0]         op_addr_ff, nxt_op_addr;
  logic                     op_erase_ff, nxt_op_erase;
  logic [1:0]               op_tgt_ff, nxt_op_tgt;
  logic                     arr_wr_ff, nxt_arr_wr;
  logic                     arr_er_ff, nxt_arr_er;
  logic                     done_flag_ff, nxt_done_flag;
  logic [15:0]              exec_ff, nxt_exec;
  fpma_pkg::fpma_unlock_t   ul_ff, nxt_ul;

  logic                     busy;
  logic                     tmr_done;
  logic                     go;
  logic                     ctl_wr;
  logic [7:0]               ctl_rd;
  logic [1:0]               tgt;

  fpma_prog_timer #(
    .CYCLES (PROG_CYCLES)
  ) u_timer (
    .clk   (REF_CLK),
    .rst   (RST),
    .start (go),
    .abort (WARM_RST),
    .busy  (busy),
    .done  (tmr_done)
  );

  // config select wins over memory select
  always_comb begin
    if (cfg_sel_ff) begin
      tgt = fpma_pkg::TGT_CONFIG;
    end else if (mem_sel_ff) begin
      tgt = fpma_pkg::TGT_FLASH;
    end else begin
      tgt = fpma_pkg::TGT_EEPROM;
    end
  end

  always_comb begin
    ctl_rd = 8'h00;
    ctl_rd[fpma_pkg::BIT_MEM_SEL]  = mem_sel_ff;
    ctl_rd[fpma_pkg::BIT_CFG_SEL]  = cfg_sel_ff;
    ctl_rd[fpma_pkg::BIT_ERASE]    = erase_ff;
    ctl_rd[fpma_pkg::BIT_ABORT]    = abort_ff;
    ctl_rd[fpma_pkg::BIT_PROG_EN]  = prog_en_ff;
    ctl_rd[fpma_pkg::BIT_START]    = start_ff;
    ctl_rd[fpma_pkg::BIT_RD_START] = rd_ff;
  end

  // unlock tracking: any other register write breaks the sequence
  always_comb begin
    nxt_ul = ul_ff;
    if (SFR_WR) begin
      if (SFR_SEL == fpma_pkg::REG_UNLOCK &&
          SFR_WDATA == fpma_pkg::UNLOCK_KEY1) begin
        nxt_ul = fpma_pkg::ST_ARMED;
      end else if (SFR_SEL == fpma_pkg::REG_UNLOCK &&
                   SFR_WDATA == fpma_pkg::UNLOCK_KEY2 &&
                   ul_ff == fpma_pkg::ST_ARMED) begin
        nxt_ul = fpma_pkg::ST_KEYED;
      end else begin
        nxt_ul = fpma_pkg::ST_IDLE;
      end
    end
    case (ul_ff)
      fpma_pkg::ST_IDLE:  ;
      fpma_pkg::ST_ARMED: ;
      fpma_pkg::ST_KEYED: ;
      default:            nxt_ul = fpma_pkg::ST_IDLE;
    endcase
  end

  // control writes are ignored while the cpu is stalled
  assign ctl_wr = SFR_WR && SFR_SEL == fpma_pkg::REG_CONTROL && !busy;
  assign go     = ctl_wr && SFR_WDATA[fpma_pkg::BIT_START] && !start_ff &&
                  prog_en_ff && ul_ff == fpma_pkg::ST_KEYED;

  always_comb begin
    nxt_mem_sel  = mem_sel_ff;
    nxt_cfg_sel  = cfg_sel_ff;
    nxt_erase    = erase_ff;
    nxt_abort    = abort_ff;
    nxt_prog_en  = prog_en_ff;
    nxt_start    = start_ff;
    nxt_rd       = 1'b0;
    nxt_op_addr  = op_addr_ff;
    nxt_op_erase = op_erase_ff;
    nxt_op_tgt   = op_tgt_ff;
    if (ctl_wr) begin
      nxt_mem_sel = SFR_WDATA[fpma_pkg::BIT_MEM_SEL];
      nxt_cfg_sel = SFR_WDATA[fpma_pkg::BIT_CFG_SEL];
      nxt_erase   = SFR_WDATA[fpma_pkg::BIT_ERASE];
      nxt_abort   = SFR_WDATA[fpma_pkg::BIT_ABORT];
      nxt_prog_en = SFR_WDATA[fpma_pkg::BIT_PROG_EN];
      // set-only bits: a written zero never clears them
      if (SFR_WDATA[fpma_pkg::BIT_RD_START] &&
          !mem_sel_ff && !cfg_sel_ff) begin
        nxt_rd = 1'b1;
      end
      if (go) begin
        nxt_start    = 1'b1;
        nxt_abort    = 1'b1;
        nxt_op_erase = erase_ff;
        nxt_op_tgt   = tgt;
        if (erase_ff) begin
          nxt_op_addr = {TBL_PTR[PTR_W-1:fpma_pkg::ERASE_LSB],
                         fpma_pkg::ERASE_LSB'(0)};
        end else begin
          nxt_op_addr = {TBL_PTR[PTR_W-1:fpma_pkg::WRITE_LSB],
                         fpma_pkg::WRITE_LSB'(0)};
        end
      end else if (SFR_WDATA[fpma_pkg::BIT_START] && !start_ff) begin
        nxt_abort = 1'b1;
      end
    end
    if (tmr_done) begin
      nxt_start = 1'b0;
      nxt_abort = 1'b0;
      if (op_erase_ff) begin
        nxt_erase = 1'b0;
      end
    end
    // warm reset kills the cycle; the abort flag and selects stay
    if (WARM_RST) begin
      nxt_start   = 1'b0;
      nxt_erase   = 1'b0;
      nxt_prog_en = 1'b0;
      nxt_rd      = 1'b0;
      nxt_abort   = abort_ff;
      nxt_mem_sel = mem_sel_ff;
      nxt_cfg_sel = cfg_sel_ff;
    end
  end

  // table transfers, both refused while the array is busy
  always_comb begin
    nxt_latch = latch_ff;
    for (int i = 0; i < HOLD_BYTES; i++) begin
      nxt_hold[i] = hold_ff[i];
    end
    if (SFR_WR && SFR_SEL == fpma_pkg::REG_LATCH) begin
      nxt_latch = SFR_WDATA;
    end
    if (TBL_FETCH && !busy) begin
      nxt_latch = TBL_PTR[0] ? MEM_RDATA[15:8] : MEM_RDATA[7:0];
    end
    // cleared only as the commit pulse carries the bytes out
    if (arr_wr_ff) begin
      for (int i = 0; i < HOLD_BYTES; i++) begin
        nxt_hold[i] = fpma_pkg::HOLD_RST;
      end
    end
    if (TBL_STORE && !busy) begin
      nxt_hold[TBL_PTR[HSEL_W-1:0]] = latch_ff;
    end
  end

  always_comb begin
    nxt_rdata = rdata_ff;
    if (SFR_RD) begin
      case (SFR_SEL)
        fpma_pkg::REG_CONTROL: nxt_rdata = ctl_rd;
        fpma_pkg::REG_UNLOCK:  nxt_rdata = 8'h00;
        fpma_pkg::REG_LATCH:   nxt_rdata = latch_ff;
        default:               nxt_rdata = 8'h00;
      endcase
    end
  end

  // commit pulses follow the timer end by one cycle
  always_comb begin
    nxt_arr_wr    = tmr_done && !op_erase_ff;
    nxt_arr_er    = tmr_done && op_erase_ff;
    nxt_done_flag = (done_flag_ff && !NVM_DONE_CLR) || tmr_done;
    nxt_exec      = FETCH_INVALID ? fpma_pkg::NOP_WORD : FETCH_WORD;
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      mem_sel_ff   <= fpma_pkg::CTL_RST_MEM_SEL;
      cfg_sel_ff   <= fpma_pkg::CTL_RST_CFG_SEL;
      erase_ff     <= fpma_pkg::CTL_RST_ERASE;
      abort_ff     <= fpma_pkg::CTL_RST_ABORT;
      prog_en_ff   <= fpma_pkg::CTL_RST_PROG_EN;
      start_ff     <= fpma_pkg::CTL_RST_START;
      rd_ff        <= fpma_pkg::CTL_RST_RD;
      latch_ff     <= fpma_pkg::LATCH_RST;
      rdata_ff     <= 8'h00;
      op_addr_ff   <= '0;
      op_erase_ff  <= 1'b0;
      op_tgt_ff    <= fpma_pkg::TGT_EEPROM;
      arr_wr_ff    <= 1'b0;
      arr_er_ff    <= 1'b0;
      done_flag_ff <= 1'b0;
      exec_ff      <= fpma_pkg::NOP_WORD;
      ul_ff        <= fpma_pkg::ST_IDLE;
      for (int i = 0; i < HOLD_BYTES; i++) begin
        hold_ff[i] <= fpma_pkg::HOLD_RST;
      end
    end else begin
      mem_sel_ff   <= nxt_mem_sel;
      cfg_sel_ff   <= nxt_cfg_sel;
      erase_ff     <= nxt_erase;
      abort_ff     <= nxt_abort;
      prog_en_ff   <= nxt_prog_en;
      start_ff     <= nxt_start;
      rd_ff        <= nxt_rd;
      latch_ff     <= nxt_latch;
      rdata_ff     <= nxt_rdata;
      op_addr_ff   <= nxt_op_addr;
      op_erase_ff  <= nxt_op_erase;
      op_tgt_ff    <= nxt_op_tgt;
      arr_wr_ff    <= nxt_arr_wr;
      arr_er_ff    <= nxt_arr_er;
      done_flag_ff <= nxt_done_flag;
      exec_ff      <= nxt_exec;
      ul_ff        <= nxt_ul;
      for (int i = 0; i < HOLD_BYTES; i++) begin
        hold_ff[i] <= nxt_hold[i];
      end
    end
  end

  always_comb begin
    for (int i = 0; i < HOLD_BYTES; i++) begin
      ARR_WDATA[8*i +: 8] = hold_ff[i];
    end
  end

  assign SFR_RDATA     = rdata_ff;
  assign MEM_RADDR     = TBL_PTR[PTR_W-1:1];
  assign EXEC_WORD     = exec_ff;
  assign FETCH_HOLD    = busy;
  assign ARR_WRITE     = arr_wr_ff;
  assign ARR_ERASE     = arr_er_ff;
  assign ARR_TARGET    = op_tgt_ff;
  assign ARR_ADDR      = op_addr_ff;
  assign EE_READ       = rd_ff;
  assign NVM_DONE_FLAG = done_flag_ff;

endmodule // fpma_top
`default_nettype wire

//--- tb/fpma_top_sva.sv
`timescale 1ns/1ps
`default_nettype none
module fpma_top_sva #(
  parameter int unsigned PROG_CYCLES = 8,
  parameter int unsigned PTR_W       = 22
) (
  input wire logic             REF_CLK,
  input wire logic             RST,
  input wire logic             WARM_RST,
  input wire logic             SFR_RD,
  input wire logic [1:0]       SFR_SEL,
  input wire logic [7:0]       SFR_RDATA,
  input wire logic [15:0]      FETCH_WORD,
  input wire logic             FETCH_INVALID,
  input wire logic [15:0]      EXEC_WORD,
  input wire logic             FETCH_HOLD,
  input wire logic             ARR_WRITE,
  input wire logic             ARR_ERASE,
  input wire logic [PTR_W-1:0] ARR_ADDR,
  input wire logic             EE_READ,
  input wire logic             NVM_DONE_CLR,
  input wire logic             NVM_DONE_FLAG
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (RST);
  // busy length kept in a counter: the real timer is far too long to unroll
  logic [31:0] cnt_ff;
  logic [31:0] nxt_cnt;
  always_comb nxt_cnt = FETCH_HOLD ? cnt_ff + 32'h1 : 32'h0;
  always_ff @(posedge REF_CLK) cnt_ff <= RST ? 32'h0 : nxt_cnt;
  sequence fin_s;
    $fell(FETCH_HOLD) && !$past(WARM_RST) && !$past(RST);
  endsequence
  hold_bound_a: assert property (cnt_ff <= PROG_CYCLES)
    else $error("busy longer than timer");
  hold_len_a: assert property (fin_s |-> cnt_ff == PROG_CYCLES)
    else $error("busy length wrong");
  done_set_a: assert property (fin_s |-> ##[0:1] NVM_DONE_FLAG)
    else $error("done flag not set");
  commit_a: assert property (fin_s |-> ##[0:2] (ARR_WRITE || ARR_ERASE))
    else $error("no commit after cycle");
  done_keep_a: assert property (
    NVM_DONE_FLAG && !NVM_DONE_CLR && !WARM_RST |=> NVM_DONE_FLAG)
    else $error("done flag lost");
  exec_word_a: assert property (
    1'b1 |=> EXEC_WORD == ($past(FETCH_INVALID)
    ? fpma_pkg::NOP_WORD : $past(FETCH_WORD)))
    else $error("exec word wrong");
  unlock_zero_a: assert property (
    SFR_RD && SFR_SEL == 2'h1 |=> SFR_RDATA == 8'h00)
    else $error("unlock reads nonzero");
  bit5_zero_a: assert property (
    SFR_RD && SFR_SEL == 2'h0 |=> !SFR_RDATA[5])
    else $error("bit 5 set");
  row_base_a: assert property (ARR_ERASE |-> ARR_ADDR[5:0] == 6'h00)
    else $error("erase base unaligned");
  blk_base_a: assert property (ARR_WRITE |-> ARR_ADDR[2:0] == 3'h0)
    else $error("write base unaligned");
  rd_pulse_a: assert property (EE_READ |=> !EE_READ)
    else $error("read pulse too long");
  cover property (ARR_ERASE);
  cover property (ARR_WRITE);
  cover property (EE_READ);
endmodule // fpma_top_sva
bind fpma_top fpma_top_sva #(.PROG_CYCLES(PROG_CYCLES), .PTR_W(PTR_W)) chk (
  .REF_CLK(REF_CLK), .RST(RST), .WARM_RST(WARM_RST), .SFR_RD(SFR_RD),
  .SFR_SEL(SFR_SEL), .SFR_RDATA(SFR_RDATA), .FETCH_WORD(FETCH_WORD),
  .FETCH_INVALID(FETCH_INVALID), .EXEC_WORD(EXEC_WORD),
  .FETCH_HOLD(FETCH_HOLD), .ARR_WRITE(ARR_WRITE), .ARR_ERASE(ARR_ERASE),
  .ARR_ADDR(ARR_ADDR), .EE_READ(EE_READ), .NVM_DONE_CLR(NVM_DONE_CLR),
  .NVM_DONE_FLAG(NVM_DONE_FLAG));
`default_nettype wire

//--- tb/fpma_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module fpma_mem_model (
  input  wire logic        clk,
  input  wire logic [20:0] raddr,
  output logic      [15:0] rdata,
  input  wire logic        wr,
  input  wire logic        er,
  input  wire logic [21:0] addr,
  input  wire logic [63:0] wdata
);
  // only 128 bytes modelled, so upper pointer bits alias
  logic [7:0] mem [128];
  assign rdata = {mem[{raddr[5:0], 1'b1}], mem[{raddr[5:0], 1'b0}]};
  initial for (int i = 0; i < 128; i++) mem[i] = i[7:0];
  always @(posedge clk) begin
    if (wr) for (int i = 0; i < 8; i++) mem[addr[6:0]+i[6:0]] = wdata[8*i+:8];
    if (er) for (int i = 0; i < 64; i++) mem[{addr[6], i[5:0]}] = 8'hff;
  end
endmodule // fpma_mem_model
`default_nettype wire

//--- tb/test_flash_program_memory_access.sv
`timescale 1ns/1ps
`default_nettype none
module test_flash_program_memory_access;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        warm = 1'b0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [1:0]  sel = 2'h0;
  logic [7:0]  wd = 8'h00;
  logic [7:0]  rdat;
  logic        fet = 1'b0;
  logic        sto = 1'b0;
  logic [21:0] ptr = 22'h0;
  logic [20:0] ra;
  logic [15:0] rw;
  logic [15:0] fw = 16'h0;
  logic        finv = 1'b0;
  logic [15:0] ew;
  logic        hold, awr, aer, eer, dflag;
  logic        dclr = 1'b0;
  logic [1:0]  tgt;
  logic [21:0] aad;
  logic [63:0] awd;
  int          failures = 0;
  int          checked = 0;
  int          cyc = 0;
  fpma_top #(.PROG_CYCLES(8)) uut (.REF_CLK(clk), .RST(rst), .WARM_RST(warm),
    .SFR_WR(wr), .SFR_RD(rd), .SFR_SEL(sel), .SFR_WDATA(wd), .SFR_RDATA(rdat),
    .TBL_FETCH(fet), .TBL_STORE(sto), .TBL_PTR(ptr), .MEM_RADDR(ra),
    .MEM_RDATA(rw), .FETCH_WORD(fw), .FETCH_INVALID(finv), .EXEC_WORD(ew),
    .FETCH_HOLD(hold), .ARR_WRITE(awr), .ARR_ERASE(aer), .ARR_TARGET(tgt),
    .ARR_ADDR(aad), .ARR_WDATA(awd), .EE_READ(eer), .NVM_DONE_CLR(dclr),
    .NVM_DONE_FLAG(dflag));
  fpma_mem_model arr (.clk(clk), .raddr(ra), .rdata(rw), .wr(awr), .er(aer),
    .addr(aad), .wdata(awd));
  always #12.5 clk = ~clk;
  task automatic chk(string n, logic [63:0] e, logic [63:0] g);
    checked++;
    if (g !== e) begin
      failures++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  // write strobe left high so back-to-back writes need no gap
  task automatic w(logic [1:0] s, logic [7:0] d);
    sel = s;
    wd = d;
    wr = 1'b1;
    @(negedge clk);
  endtask
  task automatic r(logic [1:0] s, logic [7:0] e, string n);
    wr = 1'b0;
    sel = s;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    chk(n, e, rdat);
    @(negedge clk);
  endtask
  task automatic tb(logic st, logic [21:0] p);
    wr = 1'b0;
    ptr = p;
    fet = !st;
    sto = st;
    @(negedge clk);
    fet = 1'b0;
    sto = 1'b0;
    @(negedge clk);
  endtask
  task automatic go(logic [7:0] c);
    w(2'h1, fpma_pkg::UNLOCK_KEY1);
    w(2'h1, fpma_pkg::UNLOCK_KEY2);
    w(2'h0, c);
  endtask
  task automatic settle();
    wr = 1'b0;
    repeat (40) if (hold) @(negedge clk);
    repeat (3) @(negedge clk);
  endtask
  task automatic t_regs();
    r(2'h0, 8'h00, "ctl reset");
    r(2'h2, fpma_pkg::LATCH_RST, "latch reset");
    w(2'h1, 8'h55);
    r(2'h1, 8'h00, "unlock");
    w(2'h0, 8'h20);
    r(2'h0, 8'h00, "bit5");
    w(2'h3, 8'h5a);
    r(2'h3, 8'h00, "unmapped");
    w(2'h2, 8'h3c);
    r(2'h2, 8'h3c, "latch");
    fw = 16'h1234;
    @(negedge clk);
    chk("exec", 64'h1234, ew);
    finv = 1'b1;
    @(negedge clk);
    chk("exec nop", fpma_pkg::NOP_WORD, ew);
    finv = 1'b0;
    tb(1'b0, 22'h13);
    r(2'h2, 8'h13, "fetch odd");
    tb(1'b0, 22'h20);
    r(2'h2, 8'h20, "fetch even");
    $display("test regs done");
  endtask
  task automatic t_write();
    w(2'h0, 8'h84);
    for (int i = 0; i < 8; i++) begin
      w(2'h2, 8'ha0 + i[7:0]);
      tb(1'b1, 22'h18 + 22'(i));
    end
    chk("not yet", 64'h18, arr.mem[24]);
    ptr = 22'h1d;
    go(8'h86);
    r(2'h0, 8'h8e, "ctl busy");
    chk("hold", 64'h1, hold);
    w(2'h0, 8'h00);
    tb(1'b0, 22'h00);
    settle();
    r(2'h0, 8'h84, "ctl done");
    r(2'h2, 8'ha7, "latch kept");
    chk("done", 64'h1, dflag);
    chk("target", fpma_pkg::TGT_FLASH, tgt);
    for (int i = 0; i < 8; i++) chk("blk", 8'ha0 + i, arr.mem[24+i]);
    dclr = 1'b1;
    @(negedge clk);
    dclr = 1'b0;
    chk("done clr", 64'h0, dflag);
    $display("test write done");
  endtask
  task automatic t_erase();
    ptr = 22'h4d;
    w(2'h0, 8'h94);
    go(8'h96);
    settle();
    r(2'h0, 8'h84, "erase clr");
    chk("row lo", 64'hff, arr.mem[64]);
    chk("row hi", 64'hff, arr.mem[127]);
    chk("row out", 64'h3f, arr.mem[63]);
    dclr = 1'b1;
    @(negedge clk);
    dclr = 1'b0;
    $display("test erase done");
  endtask
  task automatic t_read();
    w(2'h0, 8'h04);
    w(2'h0, 8'h05);
    chk("ee read", 64'h1, eer);
    r(2'h0, 8'h05, "rd set");
    r(2'h0, 8'h04, "rd self clr");
    w(2'h0, 8'h84);
    w(2'h0, 8'h85);
    chk("ee refused", 64'h0, eer);
    w(2'h0, 8'h80);
    go(8'h82);
    r(2'h0, 8'h88, "no enable");
    chk("no hold", 64'h0, hold);
    w(2'h0, 8'h84);
    w(2'h0, 8'h86);
    r(2'h0, 8'h8c, "no unlock");
    $display("test refuse done");
  endtask
  task automatic t_warm();
    w(2'h0, 8'hcc);
    go(8'hce);
    wr = 1'b0;
    @(negedge clk);
    chk("cfg target", fpma_pkg::TGT_CONFIG, tgt);
    warm = 1'b1;
    @(negedge clk);
    warm = 1'b0;
    repeat (2) @(negedge clk);
    chk("aborted", 64'h0, hold);
    r(2'h0, 8'hc8, "abort kept");
    chk("no done", 64'h0, dflag);
    $display("test warm done");
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      failures++;
      $display("BAD timeout expected done seen hang");
      results();
    end
  end
  initial begin
    repeat (2) @(negedge clk);
    rst = 1'b0;
    t_regs();
    t_write();
    t_erase();
    t_read();
    t_warm();
    results();
  end
endmodule // test_flash_program_memory_access
`default_nettype wire
